// File: dv/sac_link_sva.sv
// checker for the converter link: timing between host end and converter end
// assumes tb_top instantiates it beside the link, with the shortened counts
`timescale 1ns/1ps
module sac_link_chk #(
  parameter int CONV_CYC = 80,
  parameter int RISE_CYC = 20
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // host to converter
  input wire logic start_conv,
  input wire logic output_enable_n_short,
  // converter to host
  input wire logic conversion_done_n,
  input wire logic [7:0] dout,
  input wire logic dout_oe_n
);
  import sac_pkg::*;
  // ********
  // helpers
  // ********
  localparam int RISE_HI = RISE_CYC + 16;
  localparam int CONV_LO = CONV_CYC - 4;
  localparam int CONV_HI = CONV_CYC + 12;
  logic [7:0] hi_cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // saturates so a stuck start cannot wrap into a short-looking pulse
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hi_cnt <= 8'h00;
    end else if (!start_conv) begin
      hi_cnt <= 8'h00;
    end else if (hi_cnt != 8'hff) begin
      hi_cnt <= hi_cnt + 8'h01;
    end
  end
  // ********
  // properties
  // ********
  property p_start_width;
    $fell(start_conv) |-> hi_cnt >= START_PULSE_CYC;
  endproperty
  a_start_width: assert property (p_start_width) else $error("start pulse too short");
  property p_done_rise;
    $rose(start_conv) |-> ##[1:RISE_HI] conversion_done_n;
  endproperty
  a_done_rise: assert property (p_done_rise) else $error("done line late after start");
  property p_rise_needs_start;
    $rose(conversion_done_n) |-> start_conv;
  endproperty
  a_rise_needs_start: assert property (p_rise_needs_start) else $error("done rose unprompted");
  property p_conv_time;
    $fell(start_conv) |-> ##[CONV_LO:CONV_HI] $fell(conversion_done_n);
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion time off");
  property p_no_fall_in_start;
    $fell(conversion_done_n) |-> !start_conv && !$past(start_conv, 60);
  endproperty
  a_no_fall_in_start: assert property (p_no_fall_in_start) else $error("done fell too early");
  property p_read_access;
    $fell(output_enable_n_short) |-> ##[32:45] $fell(dout_oe_n);
  endproperty
  a_read_access: assert property (p_read_access) else $error("data drive timing off");
  property p_read_float;
    $rose(output_enable_n_short) |-> ##[32:45] $rose(dout_oe_n);
  endproperty
  a_read_float: assert property (p_read_float) else $error("data float timing off");
  property p_result_stable;
    (!conversion_done_n && !$past(conversion_done_n, 2) && !dout_oe_n && !$past(dout_oe_n, 2))
      |-> $stable(dout);
  endproperty
  a_result_stable: assert property (p_result_stable) else $error("result moved");
  property p_oe_high_at_start;
    $rose(start_conv) |-> output_enable_n_short && dout_oe_n;
  endproperty
  a_oe_high_at_start: assert property (p_oe_high_at_start) else $error("enable low at start");
  c_conv_done: cover property ($fell(conversion_done_n));
  c_read_drive: cover property ($fell(dout_oe_n));
  c_restart: cover property ($rose(start_conv) && !conversion_done_n);
endmodule // sac_link_chk

// File: dv/tb_top.sv
// top bench: both link ends joined, bus side driven, results compared
// assumes the shortened counts below are passed to both ends and the checker
`timescale 1ns/1ps
module tb_top;
  import sac_pkg::*;
  localparam int CONV = 80;
  localparam int RISE = 20;
  localparam logic [7:0] ADDR = 8'h40;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] analog_code = 8'h00;
  logic bipolar_mode = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] rd_data;
  logic rd_valid, rd_refused, busy, done_irq;
  wire [7:0] data_bus;
  int fail_count = 0;
  int n_checks = 0;
  int rise_dly = 0;
  int rise_cnt = 0;
  bit rise_on = 1'b0;
  logic st_q = 1'b0;
  // ********
  // structure
  // ********
  always #2 mclk = ~mclk;
  sac_link_if sac_link_if_inst (.mclk(mclk), .rst_b(rst_b));
  assign data_bus = sac_link_if_inst.dout_oe_n ? 8'hzz : sac_link_if_inst.dout;
  sac_dev #(.CONV_CYC(CONV), .RISE_CYC(RISE)) sac_dev_inst (.link(sac_link_if_inst),
    .analog_code(analog_code), .bipolar_mode(bipolar_mode));
  sac_host #(.ADC_ADDR(ADDR), .USE_DONE(1'b1), .RESULT_WAIT(200), .ACQUIRE_WAIT(10))
    sac_host_inst (.link(sac_link_if_inst), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .rd_data(rd_data), .rd_valid(rd_valid), .rd_refused(rd_refused),
    .busy(busy), .done_irq(done_irq));
  sac_link_chk #(.CONV_CYC(CONV), .RISE_CYC(RISE)) sac_link_chk_inst (.mclk(mclk),
    .rst_b(rst_b), .start_conv(sac_link_if_inst.start_conv),
    .output_enable_n_short(sac_link_if_inst.output_enable_n_short),
    .conversion_done_n(sac_link_if_inst.conversion_done_n),
    .dout(sac_link_if_inst.dout), .dout_oe_n(sac_link_if_inst.dout_oe_n));
  // cycles from start rise to done rise on the wire
  always @(posedge mclk) begin
    if (sac_link_if_inst.start_conv === 1'b1 && st_q === 1'b0) begin
      rise_on = 1'b1;
      rise_cnt = 0;
    end else if (rise_on) begin
      rise_cnt++;
      if (sac_link_if_inst.conversion_done_n === 1'b1) begin
        rise_dly = rise_cnt;
        rise_on = 1'b0;
      end
    end
    st_q = sac_link_if_inst.start_conv;
  end
  // ********
  // helpers
  // ********
  task automatic check_bits(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic check_int(input string what, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      fail_count++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask
  function automatic logic [7:0] exp_code(input logic [7:0] code, input logic bip);
    return bip ? (code ^ 8'h80) : code;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic bus_op(input logic [7:0] a, input logic w, input logic r, output logic refused);
    @(posedge mclk);
    bus_addr <= a;
    bus_wr <= w;
    bus_rd <= r;
    @(posedge mclk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    #1 refused = rd_refused;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 2000; i++) begin
      @(posedge mclk);
      #1;
      if (done_irq === 1'b1) break;
    end
    check_bits("completion", 8'h01, {7'h00, done_irq});
  endtask
  task automatic convert(input logic [7:0] code, input logic bip);
    logic r;
    @(posedge mclk);
    analog_code <= code;
    bipolar_mode <= bip;
    bus_op(ADDR, 1'b1, 1'b0, r);
    check_bits("write refused", 8'h00, {7'h00, r});
    wait_done();
  endtask
  task automatic read_back(input logic [7:0] exp);
    logic r;
    bus_op(ADDR, 1'b0, 1'b1, r);
    for (int i = 0; i < 200; i++) begin
      @(posedge mclk);
      #1;
      if (rd_valid === 1'b1) break;
    end
    check_bits("read valid", 8'h01, {7'h00, rd_valid});
    check_bits("bus data", exp, data_bus);
    check_bits("read data", exp, rd_data);
    repeat (55) @(posedge mclk);
    check_bits("bus float", 8'hzz, data_bus);
  endtask
  // ********
  // tests
  // ********
  initial begin
    logic r;
    logic [7:0] c;
    logic b;
    int d1;
    int d0;
    logic [8:0] corner [5];
    corner = '{9'h000, 9'h0ff, 9'h180, 9'h100, 9'h17f};
    void'($urandom(32'hf910));
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    #1;
    check_bits("idle link", 8'h1c, {2'b00, sac_link_if_inst.start_conv,
      sac_link_if_inst.output_enable_n_short, sac_link_if_inst.conversion_done_n,
      sac_link_if_inst.dout_oe_n, busy, done_irq});
    bus_op(8'h41, 1'b1, 1'b0, r);
    repeat (4) @(posedge mclk);
    check_bits("busy after foreign write", 8'h00, {7'h00, busy});
    $display("test reset and decode done");
    foreach (corner[k]) begin
      convert(corner[k][7:0], corner[k][8]);
      read_back(exp_code(corner[k][7:0], corner[k][8]));
    end
    $display("test corner codes done");
    @(posedge mclk);
    analog_code <= 8'h5a;
    bipolar_mode <= 1'b0;
    bus_op(ADDR, 1'b1, 1'b0, r);
    repeat (5) @(posedge mclk);
    bus_op(ADDR, 1'b1, 1'b0, r);
    check_bits("write in conversion", 8'h01, {7'h00, r});
    bus_op(ADDR, 1'b0, 1'b1, r);
    check_bits("read in conversion", 8'h01, {7'h00, r});
    wait_done();
    bus_op(ADDR, 1'b1, 1'b0, r);
    check_bits("write in acquisition", 8'h01, {7'h00, r});
    read_back(8'h5a);
    read_back(8'h5a);
    $display("test refusals done");
    convert(8'h01, 1'b0);
    read_back(8'h01);
    convert(8'h02, 1'b0);
    d1 = rise_dly;
    read_back(8'h02);
    convert(8'h04, 1'b0);
    d0 = rise_dly;
    read_back(8'h04);
    check_int("extra done delay", 8, d1 - d0);
    check_int("done rise bound", 1, int'(d0 > RISE && d0 <= RISE + 8));
    $display("test done delay done");
    for (int k = 0; k < 20; k++) begin
      c = 8'($urandom);
      b = 1'($urandom);
      convert(c, b);
      read_back(exp_code(c, b));
    end
    $display("test random codes done");
    report_and_stop();
  end
  // hang guard, well beyond the roughly 10k cycles the tests take
  initial begin
    repeat (40000) @(posedge mclk);
    fail_count++;
    $display("unexpected watchdog: expected end of tests, seen none");
    report_and_stop();
  end
endmodule // tb_top

// File: hw/sac_dev.sv
// converter end: start/done sequencing, approximation, three-state read port
// assumes start and enable arrive as pins and pass two flops here
`timescale 1ns/1ps

module sac_dev #(
  parameter int CONV_CYC = sac_pkg::CONV_TYP_CYC,
  parameter int RISE_CYC = sac_pkg::DONE_RISE_CYC
) (
  // link
  sac_link_if.dev link,
  // analog stand-in
  input wire logic [7:0] analog_code,
  input wire logic bipolar_mode
);
  import sac_pkg::*;

  localparam int BIT_CYC = CONV_CYC / CONV_BITS;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic start_s1_reg, start_s2_reg, start_d_reg;
  logic oe_s1_reg, oe_s2_reg;
  logic start_rise, start_fall;

  always_ff @(posedge link.mclk or negedge link.rst_b) begin
    if (!link.rst_b) begin
      start_s1_reg <= 1'b0;
      start_s2_reg <= 1'b0;
      start_d_reg <= 1'b0;
      oe_s1_reg <= 1'b1;
      oe_s2_reg <= 1'b1;
    end else begin
      start_s1_reg <= link.start_conv;
      start_s2_reg <= start_s1_reg;
      start_d_reg <= start_s2_reg;
      oe_s1_reg <= link.output_enable_n_short;
      oe_s2_reg <= oe_s1_reg;
    end
  end

  assign start_rise = start_s2_reg && !start_d_reg;
  // no least width is checked, so short pulses still start a conversion
  assign start_fall = !start_s2_reg && start_d_reg;

  // ****************************************
  // sequencing
  // ****************************************
  sac_dev_state_t state_reg;
  logic [15:0] cnt_reg;
  logic [15:0] rise_lim;
  logic fall_seen_reg;
  logic prev_lsb_reg;
  logic [2:0] bit_reg;
  logic reset_end, bit_end, last_bit, conv_begin;

  // longer internal reset when the old LSB was set
  assign rise_lim = prev_lsb_reg ? 16'(RISE_CYC + DONE_LSB_EXTRA_CYC)
                                 : 16'(RISE_CYC);
  assign reset_end = (state_reg == DS_RESET) && (cnt_reg == rise_lim - 16'h0001);
  assign conv_begin = (reset_end && (fall_seen_reg || start_fall))
                   || ((state_reg == DS_WAIT_FALL) && start_fall);
  assign bit_end = (state_reg == DS_CONVERT) && (cnt_reg == 16'(BIT_CYC - 1));
  assign last_bit = bit_reg == 3'h0;

  always_ff @(posedge link.mclk or negedge link.rst_b) begin
    if (!link.rst_b) begin
      state_reg <= DS_IDLE;
      cnt_reg <= 16'h0000;
      fall_seen_reg <= 1'b0;
    end else if (start_rise) begin
      state_reg <= DS_RESET;
      cnt_reg <= 16'h0000;
      fall_seen_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        DS_IDLE: begin
          cnt_reg <= 16'h0000;
        end
        DS_RESET: begin
          cnt_reg <= cnt_reg + 16'h0001;
          // a short pulse may end before the reset is through
          if (start_fall) begin
            fall_seen_reg <= 1'b1;
          end
          if (reset_end) begin
            cnt_reg <= 16'h0000;
            state_reg <= conv_begin ? DS_CONVERT : DS_WAIT_FALL;
          end
        end
        DS_WAIT_FALL: begin
          cnt_reg <= 16'h0000;
          if (conv_begin) begin
            state_reg <= DS_CONVERT;
          end
        end
        DS_CONVERT: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (bit_end) begin
            cnt_reg <= 16'h0000;
            if (last_bit) begin
              state_reg <= DS_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // approximation register
  // ****************************************
  logic [7:0] approximation_register;
  logic [7:0] target_reg;
  logic [7:0] bit_mask;

  assign bit_mask = 8'h01 << bit_reg;

  always_ff @(posedge link.mclk or negedge link.rst_b) begin
    if (!link.rst_b) begin
      approximation_register <= 8'h00;
      target_reg <= 8'h00;
      bit_reg <= 3'h7;
      prev_lsb_reg <= 1'b0;
    end else if (start_rise) begin
      prev_lsb_reg <= approximation_register[0];
      approximation_register <= 8'h00;
      bit_reg <= 3'h7;
    end else if (conv_begin) begin
      // held input: bipolar folds to offset binary by flipping the sign
      target_reg <= bipolar_mode ? {~analog_code[7], analog_code[6:0]}
                                 : analog_code;
      approximation_register <= 8'h80;
      bit_reg <= 3'h7;
    end else if (bit_end) begin
      if (approximation_register > target_reg) begin
        approximation_register <= approximation_register & ~bit_mask;
      end
      if (!last_bit) begin
        approximation_register <= (approximation_register
          & ~((approximation_register > target_reg) ? bit_mask : 8'h00))
          | (bit_mask >> 1);
        bit_reg <= bit_reg - 3'h1;
      end
    end
    // otherwise the finished result simply stays put
  end

  // ****************************************
  // done line
  // ****************************************
  logic done_n_reg;

  always_ff @(posedge link.mclk or negedge link.rst_b) begin
    if (!link.rst_b) begin
      done_n_reg <= 1'b1;
    end else if (reset_end) begin
      done_n_reg <= 1'b1;
    end else if (bit_end && last_bit) begin
      done_n_reg <= 1'b0;
    end
  end

  assign link.conversion_done_n = done_n_reg;

  // ****************************************
  // read port
  // ****************************************
  logic drive_reg;
  logic [7:0] dout_reg;
  logic [7:0] acc_cnt_reg;
  logic [7:0] flt_cnt_reg;

  always_ff @(posedge link.mclk or negedge link.rst_b) begin
    if (!link.rst_b) begin
      drive_reg <= 1'b0;
      acc_cnt_reg <= 8'h00;
      flt_cnt_reg <= 8'h00;
    end else if (!oe_s2_reg) begin
      flt_cnt_reg <= 8'h00;
      if (!drive_reg) begin
        acc_cnt_reg <= acc_cnt_reg + 8'h01;
        if (acc_cnt_reg == 8'(READ_ACCESS_CYC - 1)) begin
          drive_reg <= 1'b1;
        end
      end
    end else begin
      acc_cnt_reg <= 8'h00;
      if (drive_reg) begin
        // hold, then float well inside the worst-case limit
        flt_cnt_reg <= flt_cnt_reg + 8'h01;
        if (flt_cnt_reg == 8'(FLOAT_CYC - 1)) begin
          drive_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge link.mclk or negedge link.rst_b) begin
    if (!link.rst_b) begin
      dout_reg <= 8'h00;
    end else if (!oe_s2_reg) begin
      // tracks the register, so mid-conversion reads see partial bits
      dout_reg <= approximation_register;
    end
  end

  assign link.dout = dout_reg;
  assign link.dout_oe_n = !drive_reg;

endmodule // sac_dev

// File: hw/sac_host.sv
// bus-side controller: address decode, start pulse stretch, timed read
// assumes the converter end sits on the other side of sac_link_if
`timescale 1ns/1ps
module sac_host #(
  parameter logic [7:0] ADC_ADDR = 8'h40,
  parameter bit USE_DONE = 1'b1,
  parameter int RESULT_WAIT = sac_pkg::RESULT_WAIT_CYC,
  parameter int ACQUIRE_WAIT = sac_pkg::ACQUIRE_CYC
) (
  // link
  sac_link_if.host link,
  // processor bus
  input wire logic [7:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  // results
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic rd_refused,
  output logic busy,
  output logic done_irq
);
  import sac_pkg::*;

  // ****************************************
  // synchronisers
  // ****************************************
  logic done_s1_reg, done_s2_reg;
  logic [7:0] data_s1_reg, data_s2_reg;
  always_ff @(posedge link.mclk or negedge link.rst_b) begin
    if (!link.rst_b) begin
      done_s1_reg <= 1'b1;
      done_s2_reg <= 1'b1;
      data_s1_reg <= 8'h00;
      data_s2_reg <= 8'h00;
    end else begin
      done_s1_reg <= link.conversion_done_n;
      done_s2_reg <= done_s1_reg;
      data_s1_reg <= link.dout;
      data_s2_reg <= data_s1_reg;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  sac_host_state_t state_reg;
  logic [15:0] cnt_reg, acq_reg;
  logic start_reg, oe_n_reg;
  logic hit_wr, hit_rd, conv_end, acq_ok;

  assign hit_wr = bus_wr && (bus_addr == ADC_ADDR);
  assign hit_rd = bus_rd && (bus_addr == ADC_ADDR);
  // done line as completion flag, or blind wait without it
  assign conv_end = USE_DONE ? !done_s2_reg
                             : (cnt_reg >= 16'(RESULT_WAIT - 1));
  assign acq_ok = acq_reg >= 16'(ACQUIRE_WAIT);

  always_ff @(posedge link.mclk or negedge link.rst_b) begin
    if (!link.rst_b) begin
      state_reg <= HS_IDLE;
      cnt_reg <= 16'h0000;
      start_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      rd_refused <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      rd_refused <= 1'b0;
      unique case (state_reg)
        HS_IDLE: begin
          cnt_reg <= 16'h0000;
          if (hit_wr && acq_ok) begin
            start_reg <= 1'b1;
            state_reg <= HS_START;
          end else if (hit_rd) begin
            oe_n_reg <= 1'b0;
            state_reg <= HS_READ;
          end else if (hit_wr) begin
            rd_refused <= 1'b1;
          end
        end
        HS_START: begin
          cnt_reg <= cnt_reg + 16'h0001;
          // hold until done has risen and the least width is met
          if (done_s2_reg && cnt_reg >= 16'(START_PULSE_CYC - 1)) begin
            start_reg <= 1'b0;
            cnt_reg <= 16'h0000;
            state_reg <= HS_CONVERT;
          end
          rd_refused <= hit_rd || hit_wr;
        end
        HS_CONVERT: begin
          cnt_reg <= cnt_reg + 16'h0001;
          rd_refused <= hit_rd || hit_wr;
          if (conv_end) begin
            state_reg <= HS_IDLE;
          end
        end
        HS_READ: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg == 16'(HOST_READ_CYC - 1)) begin
            rd_data <= data_s2_reg;
            rd_valid <= 1'b1;
            oe_n_reg <= 1'b1;
            cnt_reg <= 16'h0000;
            state_reg <= HS_FLOAT;
          end
        end
        HS_FLOAT: begin
          // enable stays high and the bus must float before anything else
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg == 16'(FLOAT_MAX_CYC - 1)) begin
            state_reg <= HS_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // acquisition guard and completion flag
  // ****************************************
  always_ff @(posedge link.mclk or negedge link.rst_b) begin
    if (!link.rst_b) begin
      acq_reg <= 16'(ACQUIRE_WAIT);
      done_irq <= 1'b0;
    end else if (state_reg == HS_CONVERT && conv_end) begin
      acq_reg <= 16'h0000;
      done_irq <= 1'b1;
    end else begin
      if (!acq_ok) begin
        acq_reg <= acq_reg + 16'h0001;
      end
      if (state_reg == HS_START) begin
        done_irq <= 1'b0;
      end
    end
  end

  assign busy = (state_reg == HS_START) || (state_reg == HS_CONVERT);
  assign link.start_conv = start_reg;
  assign link.output_enable_n_short = oe_n_reg;

endmodule // sac_host

// File: hw/sac_link_if.sv
// link between the converter and its bus-side controller
// assumes the bench resolves dout onto a wire from dout_oe_n
`timescale 1ns/1ps
interface sac_link_if (
  input wire logic mclk,
  input wire logic rst_b
);
  logic start_conv;
  logic output_enable_n_short;
  logic conversion_done_n;
  logic [7:0] dout;
  logic dout_oe_n;

  modport dev (
    input mclk, rst_b, start_conv, output_enable_n_short,
    output conversion_done_n, dout, dout_oe_n
  );
  modport host (
    input mclk, rst_b, conversion_done_n, dout, dout_oe_n,
    output start_conv, output_enable_n_short
  );
endinterface

// File: hw/sac_pkg.sv
// package for the converter control link: timing counts and state types
// assumes a single 250 MHz clock shared by both ends
package sac_pkg;

  // ****************************************
  // clock
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;

  // ****************************************
  // start pulse
  // ****************************************
  localparam int START_PULSE_WIDTH_NS = 500;
  localparam int START_PULSE_CYC = (START_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_SHORT_NS = 300;
  localparam int START_SHORT_CYC = (START_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // done rise delay after start
  // ****************************************
  localparam int DONE_RISE_TYP_NS = 1000;
  localparam int DONE_RISE_MAX_NS = 1500;
  localparam int DONE_RISE_CYC = DONE_RISE_TYP_NS / CLK_PERIOD_NS;
  localparam int DONE_RISE_MAX_CYC = DONE_RISE_MAX_NS / CLK_PERIOD_NS;
  localparam int DONE_LSB_EXTRA_CYC = 8;

  // ****************************************
  // conversion duration
  // ****************************************
  localparam int CONV_MIN_US = 10;
  localparam int CONV_TYP_US = 20;
  localparam int CONV_MAX_US = 30;
  localparam int CONV_TYP_CYC = CONV_TYP_US * 1000 / CLK_PERIOD_NS;
  localparam int CONV_BITS = 8;

  // ****************************************
  // read timing
  // ****************************************
  localparam int READ_ACCESS_TYP_NS = 150;
  localparam int READ_ACCESS_MAX_NS = 250;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_HOLD_NS = 50;
  localparam int OUTPUT_FLOAT_TYP_NS = 100;
  localparam int OUTPUT_FLOAT_MAX_NS = 200;
  localparam int FLOAT_CYC = (READ_HOLD_NS + OUTPUT_FLOAT_TYP_NS) / CLK_PERIOD_NS;
  localparam int FLOAT_MAX_CYC = OUTPUT_FLOAT_MAX_NS / CLK_PERIOD_NS;
  // host waits worst-case access plus its own two-flop synchroniser
  localparam int HOST_READ_CYC =
    (READ_ACCESS_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 3;

  // ****************************************
  // host waits
  // ****************************************
  localparam int RESULT_WAIT_US = 30;
  localparam int RESULT_WAIT_CYC = RESULT_WAIT_US * 1000 / CLK_PERIOD_NS;
  localparam int ACQUIRE_US = 10;
  localparam int ACQUIRE_CYC = ACQUIRE_US * 1000 / CLK_PERIOD_NS;

  // ****************************************
  // states
  // ****************************************
  typedef enum logic [1:0] {DS_IDLE, DS_RESET, DS_WAIT_FALL, DS_CONVERT} sac_dev_state_t;
  typedef enum logic [2:0] {HS_IDLE, HS_START, HS_CONVERT, HS_READ, HS_FLOAT} sac_host_state_t;

endpackage
